/* File: hw/siv_line1_vector.sv */
// Interrupt vector generator for the second interrupt output line
`timescale 1ns/100ps
`default_nettype none
`include "siv_cfg.svh"

// Functional notes
// - Upper bits and bit zero of the vector register read zero; writes ignored.
// - Bits five to one show the code pending on the second line.
// - Priority: receive overrun, then receive, then transmission error.
// - Reading the overrun or receive code clears that flag.
// - After an overrun or receive read the field advances to the next pending source.
// - Simultaneous sources: the highest-priority code is shown.
// - Field reads zero when nothing routed to the line is pending.
// - Transmission error reports 11h; software checks enable register detail.
// - Receive reports 12h when it is the top pending source.
// - Overrun reports 13h; other nonzero codes are never produced.
module siv_line1_vector #(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 16
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire siv_pkg::siv_src_t flags_i,
   input wire siv_pkg::siv_src_t enable_i,
   input wire siv_pkg::siv_src_t level_i,
   output logic [31:0] rdata_o,
   output siv_pkg::siv_src_t flag_clr_o,
   output logic second_interrupt_line_o,
   output logic irq_o
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   generate
      if (ADDR_W < 5) begin : g_bad_addr
         $error("ADDR_W too small for the register map");
      end
      if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
         $error("CNT_W must lie in 1..32");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   siv_pkg::siv_sel_t sel_w;
   siv_pkg::siv_src_t routed_w;
   siv_pkg::siv_src_t pend_w;
   siv_pkg::siv_src_t cand_w;
   siv_pkg::siv_src_t excl_reg;
   siv_pkg::siv_src_t excl_next;
   siv_pkg::siv_src_t clr_reg;
   siv_pkg::siv_src_t clr_next;
   siv_pkg::siv_src_t pend_reg;
   logic [`SIV_VEC_W-1:0] code_w;
   logic [`SIV_VEC_W-1:0] vector_reg;
   logic [`SIV_VEC_W-1:0] vector_next;
   logic [`SIV_VEC_W-1:0] last_reg;
   logic [`SIV_VEC_W-1:0] last_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] vec_word_w;
   logic [31:0] pend_word_w;
   logic [31:0] count_word_w;
   logic [31:0] last_word_w;
   logic [31:0] status_word_w;
   logic [31:0] mask_word_w;
   logic line_reg;
   logic line_next;
   logic rd_vec_w;
   logic rd_stat_w;
   logic wr_mask_w;
   logic hit_w;
   logic bad_w;
   logic clr_ovr_w;
   logic clr_rx_w;
   logic [`SIV_EVT_W-1:0] evt_w;
   logic [`SIV_EVT_W-1:0] status_w;
   logic [`SIV_EVT_W-1:0] mask_w;
   logic irq_w;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign sel_w.vector = (addr_i == ADDR_W'(`SIV_OFF_VECTOR));
   assign sel_w.status = (addr_i == ADDR_W'(`SIV_OFF_STATUS));
   assign sel_w.mask = (addr_i == ADDR_W'(`SIV_OFF_MASK));
   assign sel_w.pend = (addr_i == ADDR_W'(`SIV_OFF_PEND));
   assign sel_w.count = (addr_i == ADDR_W'(`SIV_OFF_COUNT));
   assign sel_w.last = (addr_i == ADDR_W'(`SIV_OFF_LAST));
   assign hit_w = |sel_w;

   assign rd_vec_w = rd_i & sel_w.vector;
   assign rd_stat_w = rd_i & sel_w.status;
   // The vector register is read-only; a write there is simply dropped
   assign wr_mask_w = wr_i & sel_w.mask;
   assign bad_w = (rd_i | wr_i) & ~hit_w;

   // ----------------------------------------
   // Source qualification
   // ----------------------------------------
   // A level bit of one routes the source to the second line
   assign routed_w = flags_i & enable_i & level_i;
   // Sources just cleared by a read stay out until their flag drops,
   // so the old code is never shown twice while the clear travels
   assign pend_w = routed_w & ~excl_reg;
   // An overrun or receive source being read drops out at once, so a read in the very
   // next cycle already meets the following code
   assign cand_w = pend_w & ~clr_next;

   siv_prio_enc u_prio (
      .pend_i(cand_w),
      .code_o(code_w),
      .win_o()
   );

   // ----------------------------------------
   // Vector field
   // ----------------------------------------
   assign clr_ovr_w = rd_vec_w & (vector_reg == `SIV_CODE_OVR);
   assign clr_rx_w = rd_vec_w & (vector_reg == `SIV_CODE_RX);

   // Mask out the overrun or receive source being read so the next code shows at once
   assign vector_next = code_w;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         vector_reg <= `SIV_CODE_NONE;
      end else begin
         vector_reg <= vector_next;
      end
   end

   // ----------------------------------------
   // Flag clear pulses and exclusion
   // ----------------------------------------
   // Error flags are not cleared: software must inspect their detail
   assign clr_next.ovr = clr_ovr_w;
   assign clr_next.rx = clr_rx_w;
   assign clr_next.err = 1'b0;

   // Set beats release so a read in the flag's falling cycle still counts
   assign excl_next = clr_next | (excl_reg & flags_i);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         clr_reg <= '0;
         excl_reg <= '0;
      end else begin
         clr_reg <= clr_next;
         excl_reg <= excl_next;
      end
   end

   assign flag_clr_o = clr_reg;

   // ----------------------------------------
   // Line level
   // ----------------------------------------
   assign line_next = |pend_w;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         line_reg <= 1'b0;
      end else begin
         line_reg <= line_next;
      end
   end

   assign second_interrupt_line_o = line_reg;

   // ----------------------------------------
   // Read bookkeeping
   // ----------------------------------------
   // Counter wraps; it only serves as a software health indicator
   assign count_next = (rd_vec_w && vector_reg != `SIV_CODE_NONE) ?
                       count_reg + CNT_W'(1) : count_reg;
   assign last_next = rd_vec_w ? vector_reg : last_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         count_reg <= '0;
         last_reg <= `SIV_CODE_NONE;
         pend_reg <= '0;
      end else begin
         count_reg <= count_next;
         last_reg <= last_next;
         pend_reg <= routed_w;
      end
   end

   // ----------------------------------------
   // Events
   // ----------------------------------------
   // Rising edges of routed sources; a held flag raises no second event
   assign evt_w[`SIV_EVT_OVR] = routed_w.ovr & ~pend_reg.ovr;
   assign evt_w[`SIV_EVT_RX] = routed_w.rx & ~pend_reg.rx;
   assign evt_w[`SIV_EVT_ERR] = routed_w.err & ~pend_reg.err;
   assign evt_w[`SIV_EVT_VEC] = (vector_next != vector_reg) &
                                (vector_next != `SIV_CODE_NONE);
   assign evt_w[`SIV_EVT_BAD] = bad_w;

   siv_evt_stat #(
      .W(`SIV_EVT_W)
   ) u_evt (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .evt_i(evt_w),
      .rd_clr_i(rd_stat_w),
      .mask_wr_i(wr_mask_w),
      .mask_d_i(wdata_i[`SIV_EVT_W-1:0]),
      .status_o(status_w),
      .mask_o(mask_w),
      .irq_o(irq_w)
   );

   assign irq_o = irq_w;

   // ----------------------------------------
   // Read data words
   // ----------------------------------------
   assign vec_word_w = {{(31-`SIV_VEC_MSB){1'b0}}, vector_reg, 1'b0};
   assign status_word_w = {{(32-`SIV_EVT_W){1'b0}}, status_w};
   assign mask_word_w = {{(32-`SIV_EVT_W){1'b0}}, mask_w};
   assign pend_word_w = {26'h000_0000, flags_i, routed_w};
   assign count_word_w = 32'(count_reg);
   assign last_word_w = {{(31-`SIV_VEC_MSB){1'b0}}, last_reg, 1'b0};

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   // Unmapped reads and idle cycles return zero
   assign rdata_next = ~rd_i ? `SIV_RST_WORD :
                       sel_w.vector ? vec_word_w :
                       sel_w.status ? status_word_w :
                       sel_w.mask ? mask_word_w :
                       sel_w.pend ? pend_word_w :
                       sel_w.count ? count_word_w :
                       sel_w.last ? last_word_w :
                       `SIV_RST_WORD;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_reg <= `SIV_RST_WORD;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

endmodule : siv_line1_vector
`default_nettype wire

/* File: hw/siv_cfg.svh */
// Constants for the second-line interrupt vector block
`ifndef SIV_CFG_SVH
`define SIV_CFG_SVH

// ----------------------------------------
// Vector codes
// ----------------------------------------
`define SIV_CODE_NONE 5'h00
`define SIV_CODE_ERR 5'h11
`define SIV_CODE_RX 5'h12
`define SIV_CODE_OVR 5'h13

// ----------------------------------------
// Vector field placement
// ----------------------------------------
`define SIV_VEC_LSB 1
`define SIV_VEC_MSB 5
`define SIV_VEC_W 5

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SIV_OFF_VECTOR 8'h00
`define SIV_OFF_STATUS 8'h04
`define SIV_OFF_MASK 8'h08
`define SIV_OFF_PEND 8'h0C
`define SIV_OFF_COUNT 8'h10
`define SIV_OFF_LAST 8'h14

// ----------------------------------------
// Reset values and event bit positions
// ----------------------------------------
`define SIV_RST_WORD 32'h0000_0000
`define SIV_RST_MASK 5'h00
`define SIV_EVT_W 5
`define SIV_EVT_OVR 0
`define SIV_EVT_RX 1
`define SIV_EVT_ERR 2
`define SIV_EVT_VEC 3
`define SIV_EVT_BAD 4

`endif

/* File: hw/siv_pkg.sv */
// Types shared by the second-line interrupt vector block
package siv_pkg;

   // ----------------------------------------
   // One bit per interrupt source
   // ----------------------------------------
   typedef struct packed {
      logic ovr;
      logic rx;
      logic err;
   } siv_src_t;

   // ----------------------------------------
   // Register access decoded from the plain port
   // ----------------------------------------
   typedef struct packed {
      logic vector;
      logic status;
      logic mask;
      logic pend;
      logic count;
      logic last;
   } siv_sel_t;

endpackage : siv_pkg

/* File: hw/siv_prio_enc.sv */
// Fixed-priority selection of the pending source and its vector code
`timescale 1ns/100ps
`default_nettype none
`include "siv_cfg.svh"

module siv_prio_enc (
   input wire siv_pkg::siv_src_t pend_i,
   output logic [`SIV_VEC_W-1:0] code_o,
   output siv_pkg::siv_src_t win_o
);

   // ----------------------------------------
   // Overrun over receive over error
   // ----------------------------------------
   assign win_o.ovr = pend_i.ovr;
   assign win_o.rx = pend_i.rx & ~pend_i.ovr;
   assign win_o.err = pend_i.err & ~pend_i.rx & ~pend_i.ovr;

   assign code_o = win_o.ovr ? `SIV_CODE_OVR :
                   win_o.rx ? `SIV_CODE_RX :
                   win_o.err ? `SIV_CODE_ERR :
                   `SIV_CODE_NONE;

endmodule : siv_prio_enc
`default_nettype wire

/* File: hw/siv_evt_stat.sv */
// Sticky event status with read-clear, mask and level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "siv_cfg.svh"

module siv_evt_stat #(
   parameter int W = `SIV_EVT_W
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] evt_i,
   input wire logic rd_clr_i,
   input wire logic mask_wr_i,
   input wire logic [W-1:0] mask_d_i,
   output logic [W-1:0] status_o,
   output logic [W-1:0] mask_o,
   output logic irq_o
);

   logic irq_reg;
   logic irq_next;

   // ----------------------------------------
   // Per-bit sticky flag and mask
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         logic stat_reg;
         logic stat_next;
         logic mask_reg;
         // An event in the clearing cycle is kept: set beats clear
         assign stat_next = evt_i[gi] | (stat_reg & ~rd_clr_i);
         always_ff @(posedge mclk_i) begin
            if (reset_i) begin
               stat_reg <= 1'b0;
               mask_reg <= 1'b0;
            end else begin
               stat_reg <= stat_next;
               if (mask_wr_i) begin
                  mask_reg <= mask_d_i[gi];
               end
            end
         end
         assign status_o[gi] = stat_reg;
         assign mask_o[gi] = mask_reg;
      end
   endgenerate

   // ----------------------------------------
   // Level interrupt
   // ----------------------------------------
   assign irq_next = |(status_o & mask_o);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   assign irq_o = irq_reg;

endmodule : siv_evt_stat
`default_nettype wire

/* File: sim/siv_line1_vector_props.sv */
// Concurrent checks on the ports of the second-line vector block
`timescale 1ns/100ps
`default_nettype none

module siv_line1_vector_props #(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 16
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire siv_pkg::siv_src_t flags_i,
   input wire siv_pkg::siv_src_t enable_i,
   input wire siv_pkg::siv_src_t level_i,
   input wire logic [31:0] rdata_o,
   input wire siv_pkg::siv_src_t flag_clr_o,
   input wire logic second_interrupt_line_o,
   input wire logic irq_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic [2:0] route;
   logic vrd;
   assign route = flags_i & enable_i & level_i;
   assign vrd = rd_i && (addr_i == '0);

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_vec_rsvd;
      vrd |=> (rdata_o[31:6] == 26'h000_0000) && !rdata_o[0];
   endproperty
   a_vec_rsvd: assert property (p_vec_rsvd) else $error("vector reserved bits set");
   property p_vec_codes;
      vrd |=> rdata_o[5:1] inside {5'h00, 5'h11, 5'h12, 5'h13};
   endproperty
   a_vec_codes: assert property (p_vec_codes) else $error("reserved vector code");
   property p_none_zero;
      vrd && ($past(route) == 3'b000) && (route == 3'b000) |=> rdata_o[5:1] == 5'h00;
   endproperty
   a_none_zero: assert property (p_none_zero) else $error("vector not zero when idle");
   property p_clr_err;
      !flag_clr_o.err;
   endproperty
   a_clr_err: assert property (p_clr_err) else $error("error flag cleared by read");
   property p_ovr_cause;
      flag_clr_o.ovr |-> $past(vrd) && (rdata_o[5:1] == 5'h13);
   endproperty
   a_ovr_cause: assert property (p_ovr_cause) else $error("overrun clear without read");
   property p_rx_cause;
      flag_clr_o.rx |-> $past(vrd) && (rdata_o[5:1] == 5'h12);
   endproperty
   a_rx_cause: assert property (p_rx_cause) else $error("receive clear without read");
   property p_ovr_clr;
      vrd ##1 (rdata_o[5:1] == 5'h13) |-> flag_clr_o.ovr && !flag_clr_o.rx;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("overrun read did not clear");
   property p_line_route;
      second_interrupt_line_o |-> $past(route) != 3'b000;
   endproperty
   a_line_route: assert property (p_line_route) else $error("line high with nothing routed");
   property p_ovr_adv;
      vrd && flag_clr_o.ovr |=> rdata_o[5:1] != 5'h13;
   endproperty
   a_ovr_adv: assert property (p_ovr_adv) else $error("overrun code read twice");
   property p_rx_adv;
      vrd && flag_clr_o.rx |=> rdata_o[5:1] != 5'h12;
   endproperty
   a_rx_adv: assert property (p_rx_adv) else $error("receive code read twice");

   c_adv: cover property (vrd && flag_clr_o.ovr);
   c_ovr: cover property (flag_clr_o.ovr);
   c_rx: cover property (flag_clr_o.rx);
   c_irq: cover property ($rose(irq_o));
endmodule : siv_line1_vector_props

bind siv_line1_vector siv_line1_vector_props #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) props_u (
   .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .flags_i(flags_i), .enable_i(enable_i), .level_i(level_i),
   .rdata_o(rdata_o), .flag_clr_o(flag_clr_o),
   .second_interrupt_line_o(second_interrupt_line_o), .irq_o(irq_o));

`default_nettype wire

/* File: sim/spi_line1_interrupt_vector_tb.sv */
// Self-checking bench for the second-line interrupt vector block
`timescale 1ns/100ps
`default_nettype none

module spi_line1_interrupt_vector_tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic mclk_i = 1'b0;
   logic reset_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [2:0] flags_i;
   logic [2:0] enable_i;
   logic [2:0] level_i;
   logic [31:0] rdata_o;
   logic [2:0] flag_clr_o;
   logic second_interrupt_line_o;
   logic irq_o;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] d;
   logic [31:0] dd;
   logic [2:0] c;
   logic [2:0] src [3] = '{3'b100, 3'b010, 3'b001};
   logic [4:0] code [3] = '{5'h13, 5'h12, 5'h11};

   always #4 mclk_i = ~mclk_i;

   siv_line1_vector #(.ADDR_W(8), .CNT_W(16)) dut_u (
      .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .flags_i(flags_i), .enable_i(enable_i), .level_i(level_i),
      .rdata_o(rdata_o), .flag_clr_o(flag_clr_o),
      .second_interrupt_line_o(second_interrupt_line_o), .irq_o(irq_o));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr

   // Data and clear pulses stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
      c = flag_clr_o;
   endtask : rd

   // Two vector reads with no idle cycle between the strobes
   task automatic rd2(output logic [31:0] d1, output logic [31:0] d2);
      @(posedge mclk_i);
      addr_i <= 8'h00;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      d1 = rdata_o;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      d2 = rdata_o;
   endtask : rd2

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(what, exp, d);
   endtask : rdc

   task automatic results();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // Whole run is about ninety cycles
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         miscompares++;
         results();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      reset_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 32'h0000_0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      flags_i = 3'b000;
      enable_i = 3'b111;
      level_i = 3'b000;
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      rdc(8'h00, 32'h0000_0000, "vector idle");
      wr(8'h00, 32'hFFFF_FFFF);
      rdc(8'h00, 32'h0000_0000, "vector after write");
      @(posedge mclk_i);
      flags_i <= 3'b111;
      rdc(8'h00, 32'h0000_0000, "vector unrouted");
      @(posedge mclk_i);
      enable_i <= 3'b000;
      level_i <= 3'b111;
      rdc(8'h00, 32'h0000_0000, "vector disabled");
      @(posedge mclk_i);
      enable_i <= 3'b111;
      flags_i <= 3'b000;
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk_i);
         flags_i <= src[i];
         rd(8'h00);
         chk("vector single", {26'h000_0000, code[i], 1'b0}, d);
         chk("flag clear", {29'h0000_0000, src[i] & 3'b110}, {29'h0000_0000, c});
         rdc(8'h00, (i == 2) ? 32'h0000_0022 : 32'h0000_0000, "vector next");
         @(posedge mclk_i);
         flags_i <= 3'b000;
      end
      // All three arrive together, then drain in rank order
      @(posedge mclk_i);
      flags_i <= 3'b111;
      rdc(8'h00, 32'h0000_0026, "vector overrun first");
      rdc(8'h00, 32'h0000_0024, "vector receive next");
      rdc(8'h00, 32'h0000_0022, "vector error last");
      @(posedge mclk_i);
      flags_i <= 3'b000;
      rdc(8'h00, 32'h0000_0000, "vector empty");
      rdc(8'h10, 32'h0000_0007, "read count");
      // Back-to-back reads must already see the next source
      @(posedge mclk_i);
      flags_i <= 3'b110;
      repeat (2) @(posedge mclk_i);
      rd2(d, dd);
      chk("vector back to back first", 32'h0000_0026, d);
      chk("vector back to back next", 32'h0000_0024, dd);
      @(posedge mclk_i);
      flags_i <= 3'b000;
      // Interrupt raise, clear by read, mask
      rd(8'h04);
      wr(8'h08, 32'h0000_001F);
      rdc(8'h08, 32'h0000_001F, "mask");
      @(posedge mclk_i);
      flags_i <= 3'b010;
      repeat (4) @(posedge mclk_i);
      #1;
      chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq_o});
      chk("line raised", 32'h0000_0001, {31'h0000_0000, second_interrupt_line_o});
      rdc(8'h04, 32'h0000_000A, "status receive");
      rdc(8'h00, 32'h0000_0024, "vector receive");
      repeat (3) @(posedge mclk_i);
      #1;
      chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq_o});
      chk("line after read", 32'h0000_0000, {31'h0000_0000, second_interrupt_line_o});
      wr(8'h08, 32'h0000_0000);
      @(posedge mclk_i);
      flags_i <= 3'b001;
      repeat (4) @(posedge mclk_i);
      #1;
      chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq_o});
      rdc(8'h20, 32'h0000_0000, "unmapped");
      rdc(8'h04, 32'h0000_001C, "status error");
      rdc(8'h14, 32'h0000_0024, "last vector");
      rdc(8'h0C, 32'h0000_0009, "pending");
      results();
   end
endmodule : spi_line1_interrupt_vector_tb

`default_nettype wire
